// ### bench/nvs_cmd_status_sva.sv
/* assertions for the nvsram command and status block.
   assumes binding to nvs_cmd_status, seeing only its ports. */
`default_nettype none
module nvs_cmd_status_sva (
  // clocks and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // spi link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  // pins and state
  input wire logic vcc_ok_i,
  input wire logic wp_n_i,
  input wire logic [nvs_pkg::SR_W-1:0] status_o,
  input wire logic power_active_o,
  input wire logic hw_save_busy_pin_o,
  input wire logic autosave_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import nvs_pkg::*;
  logic [4:0] bits_q;
  logic [7:0] op_q;
  ////////////////////////////////////////
  // rising edges and opcode of the frame
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bits_q <= 5'h00;
    end else if (bits_q != 5'h1f) begin
      bits_q <= bits_q + 5'h01;
    end
  end
  always_ff @(posedge sck_i) begin
    if (bits_q < 5'h08) begin
      op_q <= {op_q[6:0], si_i};
    end
  end
  ////////////////////////////////////////
  AST_SPARE_ZERO: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    status_o[6:4] == 3'h0) else $error("spare bits not zero");
  AST_BUSY_BIT_PIN: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    status_o[SR_BUSY] |-> hw_save_busy_pin_o || $past(hw_save_busy_pin_o))
    else $error("busy bit without save or recall");
  AST_SO_OFF_DESELECTED: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cs_n_i |-> !so_oe_o) else $error("output driven while deselected");
  AST_STANDBY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    (cs_n_i && !hw_save_busy_pin_o && clk_en_i)[*6] |-> !power_active_o)
    else $error("not in standby");
  AST_ACTIVE_WHEN_BUSY: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    hw_save_busy_pin_o && $past(hw_save_busy_pin_o) |-> power_active_o)
    else $error("standby during save or recall");
  AST_NO_OUT_IN_OPCODE: assert property (@(posedge sck_i) disable iff (!arst_n_i || cs_n_i)
    bits_q < 5'h08 |-> !so_oe_o) else $error("output during opcode");
  AST_OUT_ONLY_STATUS: assert property (@(negedge sck_i) disable iff (!arst_n_i)
    so_oe_o |-> bits_q >= 5'h08 && op_q == OP_STATUS_READ_CMD)
    else $error("output for other opcode");
  AST_LATCH_NEEDS_POWER: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(status_o[SR_WEL]) |-> $past(vcc_ok_i, 4)) else $error("latch set without supply");
  AST_NO_OUT_IN_RECALL: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    hw_save_busy_pin_o && !status_o[SR_BUSY] |-> !so_oe_o)
    else $error("output during power-up recall");
endmodule
bind nvs_cmd_status nvs_cmd_status_sva u_sva (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
  .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o),
  .vcc_ok_i(vcc_ok_i), .wp_n_i(wp_n_i), .status_o(status_o),
  .power_active_o(power_active_o), .hw_save_busy_pin_o(hw_save_busy_pin_o),
  .autosave_en_o(autosave_en_o)
);
`default_nettype wire

// ### bench/nvs_spi_host.sv
/* spi master model, mode 0, 80 ns clock.
   assumes the bench calls frame() with the bus idle. */
`default_nettype none
module nvs_spi_host (
  // link
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rd = 8'h00;
  logic oe_seen = 1'b0;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  ////////////////////////////////////////
  // one frame opened by a select fall, msb first; clock idles low
  task automatic frame(input logic [15:0] d, input int n);
    #13 cs_n_o = 1'b0;
    oe_seen = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = d[15-i];
      #40 sck_o = 1'b1;
      rd = {rd[6:0], so_i};
      oe_seen = oe_seen | so_oe_i;
      #40 sck_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    si_o = ~si_o;
  endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
/* self-checking bench for the nvsram command and status block.
   assumes the spi host model and the bound checker. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic vcc_ok_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic sck, cs_n, si, so, so_oe, pwr_act, busy_pin, as_en;
  logic [7:0] status;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  nvs_cmd_status #(.RECALL_NS(2000), .SAVE_NS(4000), .DRAIN_NS(400)) uut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1), .sck_i(sck),
    .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe), .vcc_ok_i(vcc_ok_i),
    .wp_n_i(wp_n_i), .status_o(status), .power_active_o(pwr_act),
    .hw_save_busy_pin_o(busy_pin), .autosave_en_o(as_en));
  nvs_spi_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame({op, 8'h00}, 8);
    cyc(8);
  endtask
  task automatic wst(input logic [7:0] v);
    cmd(8'h06);
    host.frame({8'h01, v}, 16);
    cyc(8);
  endtask
  task automatic wait_pin(input logic lvl);
    int k;
    k = 0;
    while (busy_pin !== lvl && k < 400) begin
      cyc(1);
      k++;
    end
    chk("busy pin", {7'h0, busy_pin}, {7'h0, lvl});
  endtask
  task automatic close_out();
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_power_up();
    chk("status at reset", status, 8'h00);
    chk("standby", {7'h0, pwr_act}, 8'h00);
    chk("autosave", {7'h0, as_en}, 8'h01);
    vcc_ok_i <= 1'b1;
    wait_pin(1'b1);
    host.frame({8'h05, 8'h00}, 16);
    chk("read in recall", {7'h0, host.oe_seen}, 8'h00);
    cyc(3);
    host.frame({8'h06, 8'h00}, 8);
    wait_pin(1'b0);
    cyc(8);
    chk("latch after recall", status, 8'h00);
  endtask
  task automatic t_latch();
    cmd(8'h06);
    chk("set latch", status, 8'h02);
    cmd(8'h04);
    chk("clear latch", status, 8'h00);
  endtask
  task automatic t_status();
    wst(8'h8c);
    chk("status write", status, 8'h8c);
    host.frame({8'h05, 8'h00}, 16);
    chk("status read", host.rd, 8'h8c);
    cyc(8);
    host.frame({8'h01, 8'h00}, 16);
    cyc(8);
    chk("write needs latch", status, 8'h8c);
  endtask
  task automatic t_protect();
    wp_n_i <= 1'b0;
    wst(8'h00);
    chk("pin blocks write", status, 8'h8c);
    wp_n_i <= 1'b1;
    wst(8'h04);
    chk("pin high", status, 8'h04);
    wp_n_i <= 1'b0;
    wst(8'h88);
    chk("pin not enabled", status, 8'h88);
    wp_n_i <= 1'b1;
  endtask
  task automatic t_nv();
    cmd(8'h06);
    host.frame({8'h3c, 8'h00}, 8);
    wait_pin(1'b1);
    chk("busy bit", {7'h0, status[0]}, 8'h01);
    host.frame({8'h05, 8'h00}, 16);
    chk("busy polled", {7'h0, host.rd[0]}, 8'h01);
    wait_pin(1'b0);
    chk("after save", status, 8'h88);
    wst(8'h00);
    cmd(8'h06);
    cmd(8'h60);
    wait_pin(1'b0);
    chk("after recall", status, 8'h88);
    cmd(8'h06);
    cmd(8'h19);
    chk("autosave off", {7'h0, as_en}, 8'h00);
    cmd(8'h06);
    cmd(8'h59);
    chk("autosave on", {7'h0, as_en}, 8'h01);
  endtask
  task automatic t_opcodes();
    logic [7:0] ops [6];
    ops = '{8'h1e, 8'hff, 8'h03, 8'h13, 8'h02, 8'h12};
    for (int i = 0; i < 6; i++) begin
      cmd(8'h06);
      host.frame({ops[i], 8'h00}, 16);
      cyc(8);
      chk("no output", {7'h0, host.oe_seen}, 8'h00);
      if (i < 2) begin
        chk("latch kept", status, 8'h8a);
      end
    end
    cmd(8'h04);
  endtask
  task automatic t_power();
    vcc_ok_i <= 1'b0;
    wait_pin(1'b1);
    wait_pin(1'b0);
    vcc_ok_i <= 1'b1;
    wait_pin(1'b1);
    wait_pin(1'b0);
    cyc(8);
    chk("after power-up", status, 8'h88);
    vcc_ok_i <= 1'b0;
    cyc(40);
    chk("no save unwritten", {7'h0, busy_pin}, 8'h00);
  endtask
  ////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    cyc(2);
    t_power_up();
    t_latch();
    t_status();
    t_protect();
    t_nv();
    t_opcodes();
    t_power();
    close_out();
  end
endmodule
`default_nettype wire

// ### rtl/nvs_cmd_status.sv
/*
  command decoder and status register of a serial nvsram, with its
  power-up recall, power-down drain and automatic save sequencing.
  assumes an spi master in mode 0 or 3 on cs_n_i/sck_i/si_i, a supply
  detector level on vcc_ok_i and the protect pin on wp_n_i.
*/
`default_nettype none
module nvs_cmd_status #(
  parameter int unsigned RECALL_NS = 20000,
  parameter int unsigned SAVE_NS = 40000,
  parameter int unsigned DRAIN_NS = 2000
) (
  // system clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // spi link
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // device pins
  input wire logic vcc_ok_i,
  input wire logic wp_n_i,
  // state view
  output logic [nvs_pkg::SR_W-1:0] status_o,
  output logic power_active_o,
  output logic hw_save_busy_pin_o,
  output logic autosave_en_o
);
  import nvs_pkg::*;

  localparam logic [TMR_W-1:0] RECALL_CYC = ns_to_cyc(RECALL_NS);
  localparam logic [TMR_W-1:0] SAVE_CYC = ns_to_cyc(SAVE_NS);
  localparam logic [TMR_W-1:0] DRAIN_CYC = ns_to_cyc(DRAIN_NS);

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic link_rst_n;
  logic [BCNT_W-1:0] bcnt_q;
  logic [OP_W-1:0] sh_q;
  logic [OP_W-1:0] op_now;
  logic [OP_W-1:0] op_q;
  logic ign_q;
  logic rd_q;
  logic ld_q;
  logic [SR_W-1:0] so_sh_q;
  logic [OP_W-1:0] cmd_q;
  logic [SR_W-1:0] dat_q;
  logic tog_q;

  logic tog_s1_q, tog_s2_q, tog_s3_q;
  logic cs_s1_q, cs_s2_q;
  logic vcc_s1_q, vcc_s2_q;
  logic wp_s1_q, wp_s2_q;
  logic ev;
  logic acc;
  logic acc_wel;

  nvs_pwr_t st_q;
  logic [TMR_W-1:0] tmr_q;
  logic soft_q;
  logic down_q;
  logic armed_q;
  logic wel_q;
  logic [2:0] prot_q;
  logic [2:0] nv_prot_q;
  logic nv_ase_q;
  logic ase_q;
  logic dirty_q;
  logic busy;
  logic [SR_W-1:0] stat;
  logic [SR_W:0] pub_q;
  logic prot_lock;

  //////////////////////////////////////////////////////////////////////////
  // link domain: frame state is cleared while chip select is high

  assign link_rst_n = arst_n_i & ~cs_n_i;
  assign op_now = {sh_q[OP_W-2:0], si_i};

  // bit capture, msb first
  always_ff @(posedge sck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bcnt_q <= '0;
      sh_q <= '0;
    end else begin
      sh_q <= op_now;
      if (bcnt_q != BIT_SAT) begin
        bcnt_q <= bcnt_q + 5'h01;
      end
    end
  end

  // opcode decode; unknown or reserved opcodes lock the frame out
  always_ff @(posedge sck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      op_q <= '0;
      ign_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (bcnt_q == BIT_OPCODE_LAST) begin
      op_q <= op_now;
      ign_q <= !op_known(op_now) || !pub_q[SR_W];
      rd_q <= (op_now == OP_STATUS_READ_CMD) && pub_q[SR_W];
    end
  end

  // command hand-off to the system clock by toggle; pub_q is frozen in frame
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_q <= '0;
      dat_q <= '0;
      tog_q <= 1'b0;
    end else if (!cs_n_i) begin
      if (bcnt_q == BIT_OPCODE_LAST && op_known(op_now) && pub_q[SR_W]
          && op_now != OP_STATUS_WRITE_CMD) begin
        cmd_q <= op_now;
        tog_q <= ~tog_q;
      end else if (bcnt_q == BIT_DATA_LAST && !ign_q && op_q == OP_STATUS_WRITE_CMD) begin
        cmd_q <= op_q;
        dat_q <= op_now;
        tog_q <= ~tog_q;
      end
    end
  end

  // status read shifter, changes on falling edges, msb first
  always_ff @(negedge sck_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_sh_q <= '0;
      ld_q <= 1'b0;
    end else if (rd_q) begin
      ld_q <= 1'b1;
      if (!ld_q) begin
        so_sh_q <= pub_q[SR_W-1:0];
      end else begin
        so_sh_q <= {so_sh_q[SR_W-2:0], so_sh_q[SR_W-1]};
      end
    end
  end

  assign so_o = so_sh_q[SR_W-1];
  assign so_oe_o = ld_q & ~cs_n_i;

  //////////////////////////////////////////////////////////////////////////
  // synchronisers into the system clock

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      vcc_s1_q <= 1'b0;
      vcc_s2_q <= 1'b0;
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
    end else if (clk_en_i) begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      vcc_s1_q <= vcc_ok_i;
      vcc_s2_q <= vcc_s1_q;
      wp_s1_q <= wp_n_i;
      wp_s2_q <= wp_s1_q;
    end
  end

  assign ev = tog_s2_q ^ tog_s3_q;
  assign acc = ev && armed_q && st_q == PW_RUN && vcc_s2_q;
  assign acc_wel = acc && wel_q && op_needs_wel(cmd_q);
  assign prot_lock = prot_q[2] && !wp_s2_q;

  //////////////////////////////////////////////////////////////////////////
  // power sequencing: recall, run, drain, save

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= PW_OFF;
      tmr_q <= '0;
      soft_q <= 1'b0;
      down_q <= 1'b0;
    end else if (clk_en_i) begin
      if (tmr_q != '0) begin
        tmr_q <= tmr_q - 20'h00001;
      end
      case (st_q)
        PW_OFF: begin
          down_q <= 1'b0;
          if (vcc_s2_q) begin
            st_q <= PW_RECALL;
            tmr_q <= RECALL_CYC;
            soft_q <= 1'b0;
          end
        end
        PW_RECALL: begin
          if (!vcc_s2_q) begin
            st_q <= PW_OFF;
          end else if (tmr_q == '0) begin
            st_q <= PW_RUN;
            soft_q <= 1'b0;
          end
        end
        PW_RUN: begin
          if (!vcc_s2_q) begin
            st_q <= PW_DRAIN;
            tmr_q <= DRAIN_CYC;
          end else if (acc_wel && cmd_q == OP_SOFT_SAVE) begin
            st_q <= PW_SAVE;
            tmr_q <= SAVE_CYC;
          end else if (acc_wel && cmd_q == OP_SOFT_RECALL) begin
            st_q <= PW_RECALL;
            tmr_q <= RECALL_CYC;
            soft_q <= 1'b1;
          end
        end
        PW_DRAIN: begin
          if (tmr_q == '0) begin
            if (dirty_q && ase_q) begin
              st_q <= PW_SAVE;
              tmr_q <= SAVE_CYC;
              down_q <= 1'b1;
            end else begin
              st_q <= PW_OFF;
            end
          end
        end
        PW_SAVE: begin
          if (tmr_q == '0) begin
            st_q <= (down_q || !vcc_s2_q) ? PW_OFF : PW_RUN;
          end
        end
        default: begin
          st_q <= PW_OFF;
        end
      endcase
    end
  end

  // nonvolatile copy, written only by a completed save
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nv_prot_q <= NV_PROT_FACTORY;
      nv_ase_q <= NV_AUTOSAVE_FACTORY;
    end else if (clk_en_i && st_q == PW_SAVE && tmr_q == '0) begin
      nv_prot_q <= prot_q;
      nv_ase_q <= ase_q;
    end
  end

  // selection arming: a high chip select must be seen after recall
  // kept through soft save and soft recall so busy can be polled
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed_q <= 1'b0;
    end else if (clk_en_i) begin
      if (st_q == PW_OFF || st_q == PW_DRAIN || (st_q == PW_RECALL && !soft_q)
          || !vcc_s2_q) begin
        armed_q <= 1'b0;
      end else if (cs_s2_q) begin
        armed_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status register

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wel_q <= 1'b0;
      prot_q <= NV_PROT_FACTORY;
      ase_q <= NV_AUTOSAVE_FACTORY;
      dirty_q <= 1'b0;
    end else if (clk_en_i) begin
      if (st_q == PW_OFF) begin
        wel_q <= 1'b0;
        prot_q <= nv_prot_q;
        ase_q <= nv_ase_q;
        dirty_q <= 1'b0;
      end else if (acc) begin
        if (cmd_q == OP_SET_WRITE_LATCH_CMD) begin
          wel_q <= 1'b1;
        end else if (cmd_q == OP_CLEAR_WRITE_LATCH_CMD) begin
          wel_q <= 1'b0;
        end else if (acc_wel) begin
          wel_q <= 1'b0;
          if (op_writes_data(cmd_q)) begin
            dirty_q <= 1'b1;
          end
          if (cmd_q == OP_STATUS_WRITE_CMD && !prot_lock) begin
            prot_q <= {dat_q[SR_PPEN], dat_q[SR_BP_HI], dat_q[SR_BP_LO]};
          end
          if (cmd_q == OP_SOFT_RECALL) begin
            prot_q <= nv_prot_q;
            dirty_q <= 1'b0;
          end
          if (cmd_q == OP_AUTOSAVE_ON_CMD) begin
            ase_q <= 1'b1;
          end
          if (cmd_q == OP_AUTOSAVE_OFF_CMD) begin
            ase_q <= 1'b0;
          end
        end
      end
    end
  end

  assign busy = st_q == PW_SAVE || (st_q == PW_RECALL && soft_q);

  // status layout; spare bits always read zero
  always_comb begin
    stat = '0;
    stat[SR_BUSY] = busy;
    stat[SR_WEL] = wel_q;
    stat[SR_BP_LO] = prot_q[0];
    stat[SR_BP_HI] = prot_q[1];
    stat[SR_PPEN] = prot_q[2];
  end

  // copy for the link, refreshed only while deselected so it is stable in frame
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pub_q <= '0;
    end else if (clk_en_i && cs_s2_q) begin
      pub_q <= {armed_q, stat};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_o <= '0;
      power_active_o <= 1'b0;
      hw_save_busy_pin_o <= 1'b0;
      autosave_en_o <= NV_AUTOSAVE_FACTORY;
    end else if (clk_en_i) begin
      status_o <= stat;
      power_active_o <= (!cs_s2_q && armed_q) || st_q == PW_SAVE || st_q == PW_RECALL;
      hw_save_busy_pin_o <= st_q == PW_SAVE || st_q == PW_RECALL;
      autosave_en_o <= ase_q;
    end
  end
endmodule
`default_nettype wire

// ### rtl/nvs_pkg.sv
/*
  constants, opcodes, status layout and power states of the serial
  nvsram command decoder and status register.
  assumes a 25 MHz system clock; times are given in ns.
*/
`default_nettype none
package nvs_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned SR_W = 8;
  localparam int unsigned OP_W = 8;
  localparam int unsigned TMR_W = 20;
  localparam int unsigned BCNT_W = 5;

  // opcodes
  localparam logic [OP_W-1:0] OP_SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [OP_W-1:0] OP_CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [OP_W-1:0] OP_STATUS_READ_CMD = 8'h05;
  localparam logic [OP_W-1:0] OP_STATUS_WRITE_CMD = 8'h01;
  localparam logic [OP_W-1:0] OP_MEM_READ = 8'h03;
  localparam logic [OP_W-1:0] OP_MEM_WRITE = 8'h02;
  localparam logic [OP_W-1:0] OP_CLOCK_REGS_WRITE_CMD = 8'h12;
  localparam logic [OP_W-1:0] OP_CLOCK_REGS_READ_CMD = 8'h13;
  localparam logic [OP_W-1:0] OP_SOFT_SAVE = 8'h3c;
  localparam logic [OP_W-1:0] OP_SOFT_RECALL = 8'h60;
  localparam logic [OP_W-1:0] OP_AUTOSAVE_ON_CMD = 8'h59;
  localparam logic [OP_W-1:0] OP_AUTOSAVE_OFF_CMD = 8'h19;

  // status bit positions
  localparam int unsigned SR_BUSY = 0;
  localparam int unsigned SR_WEL = 1;
  localparam int unsigned SR_BP_LO = 2;
  localparam int unsigned SR_BP_HI = 3;
  localparam int unsigned SR_PPEN = 7;

  // reset and factory values
  localparam logic [2:0] NV_PROT_FACTORY = 3'h0;
  localparam logic NV_AUTOSAVE_FACTORY = 1'b1;

  // link bit counts
  localparam logic [BCNT_W-1:0] BIT_OPCODE_LAST = 5'h07;
  localparam logic [BCNT_W-1:0] BIT_DATA_LAST = 5'h0f;
  localparam logic [BCNT_W-1:0] BIT_SAT = 5'h10;

  typedef enum logic [2:0] {
    PW_OFF,
    PW_RECALL,
    PW_RUN,
    PW_DRAIN,
    PW_SAVE
  } nvs_pwr_t;

  function automatic logic [TMR_W-1:0] ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) begin
      c = 1;
    end
    return c[TMR_W-1:0];
  endfunction

  function automatic logic op_known(input logic [OP_W-1:0] op);
    return op inside {OP_SET_WRITE_LATCH_CMD, OP_CLEAR_WRITE_LATCH_CMD, OP_STATUS_READ_CMD,
      OP_STATUS_WRITE_CMD, OP_MEM_READ, OP_MEM_WRITE, OP_CLOCK_REGS_WRITE_CMD,
      OP_CLOCK_REGS_READ_CMD, OP_SOFT_SAVE, OP_SOFT_RECALL, OP_AUTOSAVE_ON_CMD,
      OP_AUTOSAVE_OFF_CMD};
  endfunction

  function automatic logic op_needs_wel(input logic [OP_W-1:0] op);
    return op inside {OP_STATUS_WRITE_CMD, OP_MEM_WRITE, OP_CLOCK_REGS_WRITE_CMD,
      OP_SOFT_SAVE, OP_SOFT_RECALL, OP_AUTOSAVE_ON_CMD, OP_AUTOSAVE_OFF_CMD};
  endfunction

  function automatic logic op_writes_data(input logic [OP_W-1:0] op);
    return op inside {OP_STATUS_WRITE_CMD, OP_MEM_WRITE, OP_CLOCK_REGS_WRITE_CMD};
  endfunction
endpackage
`default_nettype wire
